/* core/opc_clock_config.sv */
// How it works
// - Trim holds a six-bit signed value; bit five is the sign.
// - Bit five written is copied into bits six and seven; those are ignored.
// - Trim value range is minus thirty-two to plus thirty-one steps.
// - Auto trim locks trim writes; on disable trim loads last computed value.
// - PLL run-in-standby keeps it running; gate opens four cycles after request, two of them in the synchroniser.
// - PLL source bit: zero picks fast oscillator, one picks external clock.
// - PLL factor: 0 off, 1 times two, 2 times three, 3 reserved.
// - Slow oscillator standby keeps it on; gate opens four osc cycles after request.
// - Crystal source and start-up fields locked while enabled or stable.
// - Crystal standby keeps it on; otherwise it runs on request outside standby mode, or while auto trim is enabled.
// - With standby and start-up done, crystal clock arrives within three cycles.
// - Start-up select: 1k, 16k, 32k or 64k crystal cycles before stable.
// - External clock source type skips the start-up wait.
// - Source type zero is crystal, one is clock on crystal pin one.
// - Low-power bit puts the crystal oscillator in low-power mode.
// - Enable hands both crystal pins to the oscillator, locks source and start-up.
// - Enable bit writes only through the change protection unlock.
// - Auto trim uses the crystal as reference; crystal must be enabled.
// - Main clock status bit three reports crystal stable.
`timescale 1ns/10ps

module opc_clock_config
  import opc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire opc_pkg::opc_bus_req_s  bus_req,
  output logic [7:0]                  rdata,
  input  wire opc_pkg::opc_req_s      clk_req,
  input  wire logic                   slow_osc_tick,
  input  wire logic                   xtal_tick,
  input  wire logic                   standby_mode,
  input  wire logic [5:0]             auto_trim_value,
  output logic [7:0]                  fast_osc_trim_out,
  output logic                        auto_trim_active,
  output logic                        pll_running,
  output logic                        pll_use_ext,
  output logic [1:0]                  pll_mult,
  output logic                        pll_gate,
  output logic                        slow_osc_on,
  output logic                        slow_gate,
  output logic                        xtal_on,
  output logic                        xtal_gate,
  output logic                        xtal_pins_owned,
  output logic                        xtal_ext_clock,
  output logic                        xtal_low_power,
  output logic                        crystal_stable_flag
);
  import opc_pkg::*;

  // ==========================================================================
  // Input synchronisers for ticks and requests from other domains
  // ==========================================================================
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       slow_tick_d;
  logic       xtal_tick_d;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a      <= 5'h00;
      sync_b      <= 5'h00;
      slow_tick_d <= 1'b0;
      xtal_tick_d <= 1'b0;
    end else begin
      sync_a      <= {slow_osc_tick, xtal_tick, clk_req.pll, clk_req.int_slow, clk_req.xtal};
      sync_b      <= sync_a;
      slow_tick_d <= sync_b[4];
      xtal_tick_d <= sync_b[3];
    end
  end

  logic slow_edge;
  logic xtal_edge;
  logic req_pll;
  logic req_slow;
  logic req_xtal;
  assign slow_edge = sync_b[4] & ~slow_tick_d;
  assign xtal_edge = sync_b[3] & ~xtal_tick_d;
  assign req_pll   = sync_b[2];
  assign req_slow  = sync_b[1];
  assign req_xtal  = sync_b[0];

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] fast_osc_control;
  logic [7:0] fast_osc_trim;
  logic [7:0] pll_control;
  logic [7:0] internal_slow_osc_control;
  logic [7:0] crystal_slow_osc_control;
  logic [1:0] unlock_cnt;
  logic       unlocked;
  logic       wr_fast_ctl;
  logic       wr_trim;
  logic       wr_pll;
  logic       wr_slow;
  logic       wr_xtal;
  logic       auto_trim_enable;
  logic       xtal_cfg_locked;

  assign unlocked         = (unlock_cnt != 2'h0);
  assign wr_fast_ctl      = bus_req.wr && bus_req.addr == OPC_FAST_OSC_CONTROL_ADDR && unlocked;
  assign wr_trim          = bus_req.wr && bus_req.addr == OPC_FAST_OSC_TRIM_ADDR;
  assign wr_pll           = bus_req.wr && bus_req.addr == OPC_PLL_CONTROL_ADDR && unlocked;
  assign wr_slow          = bus_req.wr && bus_req.addr == OPC_INT_SLOW_CONTROL_ADDR && unlocked;
  assign wr_xtal          = bus_req.wr && bus_req.addr == OPC_XTAL_CONTROL_ADDR;
  assign auto_trim_enable = fast_osc_control[OPC_AUTO_TRIM_BIT];
  assign xtal_cfg_locked  = crystal_slow_osc_control[OPC_XTAL_EN_BIT] | crystal_stable_flag;

  // Change protection: key write opens a short window for protected registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_cnt <= 2'h0;
    end else if (bus_req.wr && bus_req.addr == OPC_CHANGE_UNLOCK_ADDR &&
                 bus_req.wdata == OPC_UNLOCK_KEY) begin
      unlock_cnt <= OPC_UNLOCK_CYCLES;
    end else if (unlocked) begin
      unlock_cnt <= unlock_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_osc_control <= OPC_FAST_OSC_CONTROL_RST;
    end else if (wr_fast_ctl) begin
      fast_osc_control <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_osc_trim <= OPC_FAST_OSC_TRIM_RST;
    end else if (auto_trim_enable && wr_fast_ctl && !bus_req.wdata[OPC_AUTO_TRIM_BIT]) begin
      fast_osc_trim <= {{2{auto_trim_value[5]}}, auto_trim_value};
    end else if (wr_trim && !auto_trim_enable) begin
      fast_osc_trim <= {{3{bus_req.wdata[OPC_TRIM_SIGN_BIT]}}, bus_req.wdata[4:0]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_control <= OPC_PLL_CONTROL_RST;
    end else if (wr_pll) begin
      pll_control <= {bus_req.wdata[7:6], 4'h0, bus_req.wdata[1:0]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      internal_slow_osc_control <= OPC_INT_SLOW_CONTROL_RST;
    end else if (wr_slow) begin
      internal_slow_osc_control <= {bus_req.wdata[7], 7'h00};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crystal_slow_osc_control <= OPC_XTAL_CONTROL_RST;
    end else if (wr_xtal) begin
      crystal_slow_osc_control[7] <= bus_req.wdata[7];
      crystal_slow_osc_control[OPC_XTAL_LP_BIT] <= bus_req.wdata[OPC_XTAL_LP_BIT];
      if (!xtal_cfg_locked) begin
        crystal_slow_osc_control[5:4] <= bus_req.wdata[5:4];
        crystal_slow_osc_control[OPC_XTAL_SRC_BIT] <= bus_req.wdata[OPC_XTAL_SRC_BIT];
      end
      if (unlocked) begin
        crystal_slow_osc_control[OPC_XTAL_EN_BIT] <= bus_req.wdata[OPC_XTAL_EN_BIT];
      end
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  logic [7:0] status;
  assign status = {4'h0, crystal_stable_flag, 3'h0};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OPC_MAIN_CLOCK_STATUS_ADDR: rdata <= status;
        OPC_FAST_OSC_CONTROL_ADDR:  rdata <= fast_osc_control;
        OPC_FAST_OSC_TRIM_ADDR:     rdata <= fast_osc_trim;
        OPC_PLL_CONTROL_ADDR:       rdata <= pll_control;
        OPC_INT_SLOW_CONTROL_ADDR:  rdata <= internal_slow_osc_control;
        OPC_XTAL_CONTROL_ADDR:      rdata <= crystal_slow_osc_control;
        default:                    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // PLL control
  // ==========================================================================
  logic [1:0] next_pll_mult;
  always_comb begin
    case (pll_control[1:0])
      2'h1:    next_pll_mult = OPC_PLL_X2;
      2'h2:    next_pll_mult = OPC_PLL_X3;
      default: next_pll_mult = OPC_PLL_OFF;
    endcase
  end

  logic [1:0] pll_gate_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_mult     <= 2'h0;
      pll_use_ext  <= 1'b0;
      pll_running  <= 1'b0;
      pll_gate     <= 1'b0;
      pll_gate_cnt <= 2'h0;
    end else begin
      pll_mult    <= next_pll_mult;
      pll_use_ext <= pll_control[OPC_PLL_SOURCE_BIT];
      pll_running <= (next_pll_mult != OPC_PLL_OFF) &&
                     (pll_control[OPC_RUN_STDBY_BIT] || req_pll);
      if (!req_pll || next_pll_mult == OPC_PLL_OFF) begin
        pll_gate_cnt <= 2'h0;
        pll_gate     <= 1'b0;
      end else if (pll_gate_cnt != 2'(OPC_PLL_GATE_DELAY - 1)) begin
        pll_gate_cnt <= pll_gate_cnt + 2'h1;
      end else begin
        pll_gate <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Internal slow oscillator
  // ==========================================================================
  logic [2:0] slow_gate_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_osc_on   <= 1'b0;
      slow_gate     <= 1'b0;
      slow_gate_cnt <= 3'h0;
    end else begin
      slow_osc_on <= internal_slow_osc_control[OPC_RUN_STDBY_BIT] || req_slow;
      if (!req_slow) begin
        slow_gate_cnt <= 3'h0;
        slow_gate     <= 1'b0;
      end else if (slow_gate_cnt != 3'(OPC_SLOW_GATE_DELAY)) begin
        if (slow_edge) begin
          slow_gate_cnt <= slow_gate_cnt + 3'h1;
        end
      end else begin
        slow_gate <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Crystal oscillator
  // ==========================================================================
  logic        xtal_en;
  logic        xtal_stdby;
  logic [16:0] stup_target;
  logic [16:0] stup_cnt;
  logic [1:0]  xtal_gate_cnt;

  assign xtal_en    = crystal_slow_osc_control[OPC_XTAL_EN_BIT];
  assign xtal_stdby = crystal_slow_osc_control[OPC_RUN_STDBY_BIT];

  always_comb begin
    case (crystal_slow_osc_control[5:4])
      2'h0:    stup_target = OPC_STUP_1K;
      2'h1:    stup_target = OPC_STUP_16K;
      2'h2:    stup_target = OPC_STUP_32K;
      default: stup_target = OPC_STUP_64K;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_on         <= 1'b0;
      xtal_pins_owned <= 1'b0;
      xtal_ext_clock  <= 1'b0;
      xtal_low_power  <= 1'b0;
    end else begin
      xtal_on         <= xtal_en && (xtal_stdby || (req_xtal && !standby_mode) ||
                         auto_trim_enable);
      xtal_pins_owned <= xtal_en;
      xtal_ext_clock  <= crystal_slow_osc_control[OPC_XTAL_SRC_BIT];
      xtal_low_power  <= crystal_slow_osc_control[OPC_XTAL_LP_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stup_cnt            <= 17'h00000;
      crystal_stable_flag <= 1'b0;
    end else if (!xtal_on) begin
      stup_cnt            <= 17'h00000;
      crystal_stable_flag <= 1'b0;
    end else if (crystal_slow_osc_control[OPC_XTAL_SRC_BIT]) begin
      crystal_stable_flag <= 1'b1;
    end else if (stup_cnt >= stup_target) begin
      crystal_stable_flag <= 1'b1;
    end else if (xtal_edge) begin
      stup_cnt <= stup_cnt + 17'h00001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_gate     <= 1'b0;
      xtal_gate_cnt <= 2'h0;
    end else if (!req_xtal || !crystal_stable_flag) begin
      xtal_gate     <= 1'b0;
      xtal_gate_cnt <= 2'h0;
    end else if (xtal_gate_cnt != 2'(OPC_XTAL_GATE_DELAY - 1)) begin
      if (xtal_edge) begin
        xtal_gate_cnt <= xtal_gate_cnt + 2'h1;
      end
    end else begin
      xtal_gate <= 1'b1;
    end
  end

  // ==========================================================================
  // Trim outputs
  // ==========================================================================
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_osc_trim_out <= 8'h00;
      auto_trim_active  <= 1'b0;
    end else begin
      fast_osc_trim_out <= fast_osc_trim;
      auto_trim_active  <= auto_trim_enable && xtal_en;
    end
  end

endmodule

/* core/opc_pkg.sv */
package opc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OPC_MAIN_CLOCK_STATUS_ADDR  = 8'h03;
  localparam logic [7:0] OPC_FAST_OSC_CONTROL_ADDR   = 8'h08;
  localparam logic [7:0] OPC_FAST_OSC_TRIM_ADDR      = 8'h09;
  localparam logic [7:0] OPC_PLL_CONTROL_ADDR        = 8'h10;
  localparam logic [7:0] OPC_INT_SLOW_CONTROL_ADDR   = 8'h18;
  localparam logic [7:0] OPC_XTAL_CONTROL_ADDR       = 8'h1c;
  localparam logic [7:0] OPC_CHANGE_UNLOCK_ADDR      = 8'h20;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] OPC_PLL_CONTROL_RST         = 8'h00;
  localparam logic [7:0] OPC_INT_SLOW_CONTROL_RST    = 8'h00;
  localparam logic [7:0] OPC_XTAL_CONTROL_RST        = 8'h00;
  localparam logic [7:0] OPC_FAST_OSC_TRIM_RST       = 8'h00;
  localparam logic [7:0] OPC_FAST_OSC_CONTROL_RST    = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int OPC_RUN_STDBY_BIT   = 7;
  localparam int OPC_PLL_SOURCE_BIT  = 6;
  localparam int OPC_AUTO_TRIM_BIT   = 0;
  localparam int OPC_TRIM_SIGN_BIT   = 5;
  localparam int OPC_XTAL_STUP_LSB   = 4;
  localparam int OPC_XTAL_SRC_BIT    = 2;
  localparam int OPC_XTAL_LP_BIT     = 1;
  localparam int OPC_XTAL_EN_BIT     = 0;
  localparam int OPC_XTAL_STABLE_BIT = 3;

  // Unlock key and window for protected writes
  localparam logic [7:0] OPC_UNLOCK_KEY    = 8'hd8;
  localparam logic [1:0] OPC_UNLOCK_CYCLES = 2'h3;

  // ==========================================================================
  // Gate delays and crystal start-up counts
  // ==========================================================================
  localparam int OPC_PLL_GATE_DELAY   = 2;
  localparam int OPC_SLOW_GATE_DELAY  = 4;
  localparam int OPC_XTAL_GATE_DELAY  = 3;
  localparam logic [16:0] OPC_STUP_1K  = 17'h00400;
  localparam logic [16:0] OPC_STUP_16K = 17'h04000;
  localparam logic [16:0] OPC_STUP_32K = 17'h08000;
  localparam logic [16:0] OPC_STUP_64K = 17'h10000;

  typedef enum logic [1:0] {
    OPC_PLL_OFF,
    OPC_PLL_X2,
    OPC_PLL_X3
  } opc_pll_mult_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } opc_bus_req_s;

  typedef struct packed {
    logic pll;
    logic int_slow;
    logic xtal;
  } opc_req_s;

endpackage

/* dv/opc_clock_config_props.sv */
`timescale 1ns/10ps
// ========================================
// Port checker
// ========================================
module opc_clock_config_props
  import opc_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire opc_pkg::opc_bus_req_s bus_req,
  input wire logic [7:0]            rdata,
  input wire logic [7:0]            fast_osc_trim_out,
  input wire logic                  auto_trim_active,
  input wire logic                  pll_use_ext,
  input wire logic [1:0]            pll_mult,
  input wire logic                  xtal_on,
  input wire logic                  xtal_gate,
  input wire logic                  crystal_stable_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] unl;
  logic [1:0] mexp;
  logic       wr_pll;
  logic       wr_trim;
  logic       rd_stat;
  logic       open_w;
  logic       ate;
  assign mexp    = (bus_req.wdata[1:0] == 2'h3) ? 2'h0 : bus_req.wdata[1:0];
  assign open_w  = (unl[2:0] != 3'h0);
  assign wr_pll  = bus_req.wr && (bus_req.addr == OPC_PLL_CONTROL_ADDR);
  assign wr_trim = bus_req.wr && (bus_req.addr == OPC_FAST_OSC_TRIM_ADDR);
  assign rd_stat = bus_req.rd && (bus_req.addr == OPC_MAIN_CLOCK_STATUS_ADDR);
  // Unlock history, bit 0 is the previous edge; auto trim enable as software set it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unl <= 6'h00;
      ate <= 1'b0;
    end else begin
      unl <= {unl[4:0], bus_req.wr && (bus_req.addr == OPC_CHANGE_UNLOCK_ADDR)
              && (bus_req.wdata == OPC_UNLOCK_KEY)};
      if (bus_req.wr && (bus_req.addr == OPC_FAST_OSC_CONTROL_ADDR) && open_w) begin
        ate <= bus_req.wdata[OPC_AUTO_TRIM_BIT];
      end
    end
  end
  sequence s_pll_open; wr_pll && open_w; endsequence
  sequence s_pll_shut; wr_pll && (unl == 6'h00); endsequence
  sequence s_trim_free; wr_trim && !ate; endsequence
  property p_pll_mult; s_pll_open |-> ##2 pll_mult == $past(mexp, 2); endproperty
  property p_pll_src; s_pll_open |-> ##2 pll_use_ext == $past(bus_req.wdata[6], 2); endproperty
  property p_pll_shut;
    s_pll_shut |-> ##1 $stable({pll_mult, pll_use_ext}) ##1 $stable({pll_mult, pll_use_ext});
  endproperty
  property p_mult_ok; pll_mult != 2'h3; endproperty
  property p_trim_val;
    s_trim_free |-> ##2 fast_osc_trim_out ==
      {{3{$past(bus_req.wdata[5], 2)}}, $past(bus_req.wdata[4:0], 2)};
  endproperty
  property p_trim_sign; fast_osc_trim_out[7:6] == {2{fast_osc_trim_out[5]}}; endproperty
  property p_stat;
    rd_stat ##0 $stable(crystal_stable_flag) ##1 $stable(crystal_stable_flag)
      |-> rdata[OPC_XTAL_STABLE_BIT] == crystal_stable_flag;
  endproperty
  property p_gate; $rose(xtal_gate) |-> crystal_stable_flag; endproperty
  property p_stable; $rose(crystal_stable_flag) |-> xtal_on; endproperty
  property p_auto_gate; auto_trim_active |-> $past(ate); endproperty
  a_pll_mult: assert property (p_pll_mult) else $error("pll factor not applied");
  a_pll_src: assert property (p_pll_src) else $error("pll source not applied");
  a_pll_shut: assert property (p_pll_shut) else $error("locked pll write took effect");
  a_mult_ok: assert property (p_mult_ok) else $error("reserved pll factor driven");
  a_trim_val: assert property (p_trim_val) else $error("trim write wrong");
  a_trim_sign: assert property (p_trim_sign) else $error("trim sign not mirrored");
  a_stat: assert property (p_stat) else $error("status stable bit wrong");
  a_gate: assert property (p_gate) else $error("crystal gate before stable");
  a_stable: assert property (p_stable) else $error("stable while crystal off");
  a_auto_gate: assert property (p_auto_gate) else $error("auto trim active while off");
endmodule

bind opc_clock_config opc_clock_config_props u_props (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
  .fast_osc_trim_out(fast_osc_trim_out), .auto_trim_active(auto_trim_active),
  .pll_use_ext(pll_use_ext), .pll_mult(pll_mult), .xtal_on(xtal_on),
  .xtal_gate(xtal_gate), .crystal_stable_flag(crystal_stable_flag)
);

/* dv/opc_clock_config_tb_top.sv */
`timescale 1ns/10ps
module opc_clock_config_tb_top;
  import opc_pkg::*;
  typedef struct {string n; logic [7:0] e; logic [7:0] m;} opc_note_s;
  logic         clk, sys_rst, slow_osc_tick, xtal_tick, standby_mode, rd_seen;
  opc_bus_req_s bus_req;
  opc_req_s     clk_req;
  logic [5:0]   auto_trim_value;
  logic [7:0]   rdata, fast_osc_trim_out, d, last;
  logic [1:0]   pll_mult;
  logic         auto_trim_active, pll_running, pll_use_ext, pll_gate, slow_osc_on, slow_gate;
  logic         xtal_on, xtal_gate, xtal_pins_owned, xtal_ext_clock, xtal_low_power;
  logic         crystal_stable_flag;
  int           err_count, checks_done;
  opc_note_s    notes[$];

  opc_clock_config dut (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata), .clk_req(clk_req),
    .slow_osc_tick(slow_osc_tick), .xtal_tick(xtal_tick), .standby_mode(standby_mode),
    .auto_trim_value(auto_trim_value), .fast_osc_trim_out(fast_osc_trim_out),
    .auto_trim_active(auto_trim_active), .pll_running(pll_running),
    .pll_use_ext(pll_use_ext), .pll_mult(pll_mult), .pll_gate(pll_gate),
    .slow_osc_on(slow_osc_on), .slow_gate(slow_gate), .xtal_on(xtal_on),
    .xtal_gate(xtal_gate), .xtal_pins_owned(xtal_pins_owned),
    .xtal_ext_clock(xtal_ext_clock), .xtal_low_power(xtal_low_power),
    .crystal_stable_flag(crystal_stable_flag)
  );

  // ========================================
  // Clocks and oscillator ticks
  // ========================================
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    xtal_tick = 1'b0;
    forever #11 xtal_tick = ~xtal_tick;
  end
  initial begin
    slow_osc_tick = 1'b0;
    forever #9 slow_osc_tick = ~slow_osc_tick;
  end

  // ========================================
  // Tasks
  // ========================================
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (e !== g) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic uwr(logic [7:0] a, logic [7:0] v);
    wr(OPC_CHANGE_UNLOCK_ADDR, OPC_UNLOCK_KEY);
    wr(a, v);
  endtask
  task automatic rd(string n, logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    @(posedge clk);
    notes.push_back('{n, e, m});
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen === 1'b1 && notes.size() > 0) begin
      chk(notes[0].n, notes[0].e & notes[0].m, rdata & notes[0].m);
      void'(notes.pop_front());
    end
    rd_seen <= bus_req.rd;
  end

  initial begin
    #200000;
    err_count++;
    conclude();
  end

  // ========================================
  // Main sequence
  // ========================================
  initial begin
    sys_rst = 1'b1; bus_req = '0; clk_req = '0; standby_mode = 1'b0;
    auto_trim_value = 6'h00; err_count = 0; checks_done = 0;
    void'($urandom(80));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd("pll_ctl", OPC_PLL_CONTROL_ADDR, OPC_PLL_CONTROL_RST);
    rd("slow_ctl", OPC_INT_SLOW_CONTROL_ADDR, OPC_INT_SLOW_CONTROL_RST);
    rd("xtal_ctl", OPC_XTAL_CONTROL_ADDR, OPC_XTAL_CONTROL_RST);
    rd("trim", OPC_FAST_OSC_TRIM_ADDR, OPC_FAST_OSC_TRIM_RST);
    wr(8'h7f, 8'h5a);
    rd("unmapped", 8'h7f, 8'h00);
    wr(OPC_PLL_CONTROL_ADDR, 8'h81);
    rd("pll_locked", OPC_PLL_CONTROL_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = {1'b1, i[0], 4'h0, i[1:0]};
      uwr(OPC_PLL_CONTROL_ADDR, d);
      rd("pll_ctl", OPC_PLL_CONTROL_ADDR, d);
      chk("pll_mult", (i == 3) ? 8'h00 : {6'h0, i[1:0]}, {6'h0, pll_mult});
      chk("pll_use_ext", {7'h0, i[0]}, {7'h0, pll_use_ext});
    end
    uwr(OPC_PLL_CONTROL_ADDR, 8'h81);
    standby_mode <= 1'b1;
    step(3);
    chk("pll_running", 8'h01, {7'h0, pll_running});
    clk_req.pll <= 1'b1;
    step(2);
    chk("pll_gate_early", 8'h00, {7'h0, pll_gate});
    repeat (10) if (pll_gate !== 1'b1) step(1);
    chk("pll_gate", 8'h01, {7'h0, pll_gate});
    uwr(OPC_INT_SLOW_CONTROL_ADDR, 8'h80);
    rd("slow_ctl", OPC_INT_SLOW_CONTROL_ADDR, 8'h80);
    chk("slow_on", 8'h01, {7'h0, slow_osc_on});
    clk_req.int_slow <= 1'b1;
    step(6);
    chk("slow_gate_early", 8'h00, {7'h0, slow_gate});
    repeat (40) if (slow_gate !== 1'b1) step(1);
    chk("slow_gate", 8'h01, {7'h0, slow_gate});
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h20 : (i == 1) ? 8'hdf : 8'($urandom);
      last = {{3{d[5]}}, d[4:0]};
      wr(OPC_FAST_OSC_TRIM_ADDR, d);
      rd("trim", OPC_FAST_OSC_TRIM_ADDR, last);
      chk("trim_out", last, fast_osc_trim_out);
    end
    auto_trim_value <= 6'($urandom);
    uwr(OPC_FAST_OSC_CONTROL_ADDR, 8'h01);
    wr(OPC_FAST_OSC_TRIM_ADDR, 8'h05);
    rd("trim_locked", OPC_FAST_OSC_TRIM_ADDR, last);
    chk("auto_idle", 8'h00, {7'h0, auto_trim_active});
    uwr(OPC_FAST_OSC_CONTROL_ADDR, 8'h00);
    rd("trim_auto", OPC_FAST_OSC_TRIM_ADDR, {{3{auto_trim_value[5]}}, auto_trim_value[4:0]});
    wr(OPC_XTAL_CONTROL_ADDR, 8'h96);
    rd("xtal_ctl", OPC_XTAL_CONTROL_ADDR, 8'h96);
    chk("xtal_modes", 8'h03, {6'h0, xtal_ext_clock, xtal_low_power});
    uwr(OPC_XTAL_CONTROL_ADDR, 8'h97);
    repeat (60) if (crystal_stable_flag !== 1'b1) step(1);
    rd("status", OPC_MAIN_CLOCK_STATUS_ADDR, 8'h08, 8'h08);
    chk("xtal_own", 8'h03, {6'h0, xtal_pins_owned, xtal_on});
    wr(OPC_XTAL_CONTROL_ADDR, 8'h82);
    rd("xtal_held", OPC_XTAL_CONTROL_ADDR, 8'h97);
    clk_req.xtal <= 1'b1;
    repeat (30) if (xtal_gate !== 1'b1) step(1);
    chk("xtal_gate", 8'h01, {7'h0, xtal_gate});
    clk_req.xtal <= 1'b0;
    uwr(OPC_XTAL_CONTROL_ADDR, 8'h96);
    repeat (60) if (crystal_stable_flag !== 1'b0) step(1);
    chk("stable_off", 8'h00, {7'h0, crystal_stable_flag});
    wr(OPC_XTAL_CONTROL_ADDR, 8'h82);
    rd("xtal_free", OPC_XTAL_CONTROL_ADDR, 8'h82);
    uwr(OPC_XTAL_CONTROL_ADDR, 8'h83);
    step(4000);
    chk("stable_wait", 8'h00, {7'h0, crystal_stable_flag});
    repeat (3000) if (crystal_stable_flag !== 1'b1) step(1);
    chk("stable_done", 8'h01, {7'h0, crystal_stable_flag});
    uwr(OPC_FAST_OSC_CONTROL_ADDR, 8'h01);
    step(2);
    chk("auto_active", 8'h01, {7'h0, auto_trim_active});
    wr(OPC_XTAL_CONTROL_ADDR, 8'h03);
    step(3);
    chk("xtal_auto_on", 8'h01, {7'h0, xtal_on});
    uwr(OPC_FAST_OSC_CONTROL_ADDR, 8'h00);
    step(3);
    chk("xtal_idle", 8'h00, {7'h0, xtal_on});
    standby_mode <= 1'b0;
    clk_req.xtal <= 1'b1;
    step(4);
    chk("xtal_req", 8'h01, {7'h0, xtal_on});
    step(2);
    conclude();
  end
endmodule
